/* File: hw/fcsm_pkg.sv */
// Constants and types shared by the flash command sequence monitor
package fcsm_pkg;

  // Register byte offsets inside the register window
  localparam logic [7:0] OFF_CLKDIV = 8'h00;
  localparam logic [7:0] OFF_PROT   = 8'h04;
  localparam logic [7:0] OFF_USTAT  = 8'h08;
  localparam logic [7:0] OFF_CMD    = 8'h0C;
  localparam logic [7:0] OFF_STAT   = 8'h10;
  localparam logic [7:0] OFF_CAUSE  = 8'h14;

  // Address decode of the array window
  localparam int ARRAY_SEL_BIT = 19;
  localparam int SECTOR_LSB    = 14;
  localparam int SECTOR_W      = 5;

  // Field positions of the user status register
  localparam int USTAT_COMMAND_BUFFER_EMPTY_FLAG_BIT  = 7;
  localparam int USTAT_COMMAND_COMPLETE_FLAG_BIT   = 6;
  localparam int USTAT_PROTECTION_VIOLATION_FLAG_BIT  = 5;
  localparam int USTAT_ACCESS_ERROR_FLAG_BIT = 4;

  // Field widths and positions of the divider register
  localparam int DIV_W          = 6;
  localparam int DIV_LOADED_BIT = 7;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // User command codes
  localparam logic [7:0] CMD_PROGRAM    = 8'h01;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h02;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h03;
  localparam logic [7:0] CMD_VERIFY     = 8'h04;

  // Execution lengths in divided clock ticks
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] TICKS_PROGRAM = 16'h0020;
  localparam logic [CNT_W-1:0] TICKS_ERASE   = 16'h0100;
  localparam logic [CNT_W-1:0] TICKS_MASS    = 16'h0400;
  localparam logic [CNT_W-1:0] TICKS_VERIFY  = 16'h0008;

  // Value returned by array reads while a command runs
  localparam logic [31:0] ARRAY_INVALID_WORD = 32'hFFFF_FFFF;

  // Reset values
  localparam logic [31:0] PROT_RESET = 32'h0000_0000;
  localparam logic [7:0]  CMD_RESET  = 8'h00;

  // Cause codes of the last refused step
  typedef enum logic [3:0] {
    CAUSE_NONE     = 4'h0,
    CAUSE_NO_DIV   = 4'h1,
    CAUSE_EMU      = 4'h2,
    CAUSE_SIZE     = 4'h3,
    CAUSE_NOT_EMPT = 4'h4,
    CAUSE_BAD_CMD  = 4'h5,
    CAUSE_NOT_CMD  = 4'h6,
    CAUSE_SECOND   = 4'h7,
    CAUSE_NOT_LNCH = 4'h8,
    CAUSE_STOP     = 4'h9,
    CAUSE_CB_ABORT = 4'hA,
    CAUSE_PROT     = 4'hB,
    CAUSE_MASS     = 4'hC,
    CAUSE_NO_DATA  = 4'hD
  } fcsm_cause_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_DATA = 2'b01,
    SEQ_CMD  = 2'b11
  } fcsm_seq_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0]  size;
    logic        write;
  } fcsm_req_s;

  typedef struct packed {
    logic [DIV_W-1:0] presc;
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
  } fcsm_tmr_s;

  typedef struct packed {
    fcsm_req_s        req;
    logic             wr_pend;
    logic             rd_pend;
    logic             hreadyout;
    logic [1:0]       hresp;
    logic [31:0]      hrdata;
    logic             stop_s1;
    logic             stop_s2;
    logic             stop_s3;
    logic             emu_s1;
    logic             emu_s2;
    fcsm_seq_e        state;
    logic             queued;
    logic [DIV_W-1:0] div;
    logic             div_loaded;
    logic [31:0]      prot;
    logic [7:0]       cmd;
    logic [31:0]      arr_data;
    logic             access_error_flag;
    logic             protection_violation_flag;
    fcsm_cause_e      cause;
    logic             hv_on;
  } fcsm_state_s;

endpackage

/* File: hw/fcsm_exec_timer.sv */
// Command execution timer with its own divided tick
`timescale 1ns/1ps
module fcsm_exec_timer
  import fcsm_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [DIV_W-1:0] div_val,
  input  wire logic             start,
  input  wire logic [7:0]       start_cmd,
  input  wire logic             abort,
  output logic                  busy,
  output logic                  done
);

  fcsm_tmr_s s_q;
  fcsm_tmr_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (abort) begin
      // Stop entry cuts the high voltage at once
      s_d.busy = 1'b0;
      s_d.cnt  = '0;
    end else if (start && !s_q.busy) begin
      s_d.busy  = 1'b1;
      s_d.presc = div_val;
      unique case (start_cmd)
        CMD_PROGRAM:    s_d.cnt = TICKS_PROGRAM;
        CMD_PAGE_ERASE: s_d.cnt = TICKS_ERASE;
        CMD_MASS_ERASE: s_d.cnt = TICKS_MASS;
        default:        s_d.cnt = TICKS_VERIFY;
      endcase
    end else if (s_q.busy) begin
      if (s_q.presc == '0) begin
        s_d.presc = div_val;
        if (s_q.cnt <= 16'h0001) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.cnt  = '0;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end else begin
        s_d.presc = s_q.presc - 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule

/* File: hw/fcsm_top.sv */
// Flash command sequence monitor with its AHB-Lite register slave
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module fcsm_top
  import fcsm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  input  wire logic        stop_mode_req,
  input  wire logic        emulation_mode,
  output logic             high_voltage_on
);

  fcsm_state_s s_q;
  fcsm_state_s s_d;

  logic                tmr_busy;
  logic                tmr_done;
  logic                tmr_start;
  logic                tmr_abort;
  logic                stop_rise;
  logic                command_buffer_empty_flag;
  logic                command_complete_flag;
  logic                acc_set;
  logic                pv_set;
  logic                acc_clr;
  logic                pv_clr;
  logic                is_array;
  logic [7:0]          off;
  logic [SECTOR_W-1:0] sector;
  logic [31:0]         rdata;
  fcsm_cause_e         cause_new;

  fcsm_exec_timer u_timer (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_val   (s_q.div),
    .start     (tmr_start),
    .start_cmd (s_q.cmd),
    .abort     (tmr_abort),
    .busy      (tmr_busy),
    .done      (tmr_done)
  );

  // The buffer is empty only with no sequence open and nothing queued
  assign command_buffer_empty_flag    = (s_q.state == SEQ_IDLE) && !s_q.queued;
  assign command_complete_flag     = !tmr_busy && !s_q.queued;
  assign is_array = s_q.req.addr[ARRAY_SEL_BIT];
  assign off      = s_q.req.addr[7:0];
  assign sector   = s_q.req.addr[SECTOR_LSB +: SECTOR_W];
  // Edge is taken from the second and third stages, never the first
  assign stop_rise = s_q.stop_s2 && !s_q.stop_s3;

  // Read data for the register window and the array window
  always_comb begin
    rdata = 32'h0000_0000;
    if (is_array) begin
      // Array contents are not modelled: the last accepted word is returned when no command runs or waits
      if (!command_complete_flag) begin
        rdata = ARRAY_INVALID_WORD;
      end else begin
        rdata = s_q.arr_data;
      end
    end else begin
      unique case (off)
        OFF_CLKDIV: begin
          rdata[DIV_W-1:0]      = s_q.div;
          rdata[DIV_LOADED_BIT] = s_q.div_loaded;
        end
        OFF_PROT: begin
          rdata = s_q.prot;
        end
        OFF_USTAT: begin
          rdata[USTAT_COMMAND_BUFFER_EMPTY_FLAG_BIT]  = command_buffer_empty_flag;
          rdata[USTAT_COMMAND_COMPLETE_FLAG_BIT]   = command_complete_flag;
          rdata[USTAT_PROTECTION_VIOLATION_FLAG_BIT]  = s_q.protection_violation_flag;
          rdata[USTAT_ACCESS_ERROR_FLAG_BIT] = s_q.access_error_flag;
        end
        OFF_CMD: begin
          rdata[7:0] = s_q.cmd;
        end
        OFF_STAT: begin
          rdata[1:0] = s_q.state;
          rdata[2]   = s_q.queued;
          rdata[3]   = tmr_busy;
        end
        OFF_CAUSE: begin
          rdata[3:0] = s_q.cause;
        end
        default: begin
          rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_comb begin
    s_d       = s_q;
    acc_set   = 1'b0;
    pv_set    = 1'b0;
    acc_clr   = 1'b0;
    pv_clr    = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    cause_new = CAUSE_NONE;

    // Pin synchronisers
    s_d.stop_s1 = stop_mode_req;
    s_d.stop_s2 = s_q.stop_s1;
    s_d.stop_s3 = s_q.stop_s2;
    s_d.emu_s1  = emulation_mode;
    s_d.emu_s2  = s_q.emu_s1;

    // Bus: reads take one wait state so that a write just before is seen
    s_d.hreadyout = 1'b1;
    s_d.hresp     = HRESP_OKAY;
    s_d.wr_pend   = 1'b0;
    if (s_q.rd_pend) begin
      s_d.hrdata  = rdata;
      s_d.rd_pend = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      s_d.req.addr  = haddr;
      s_d.req.size  = hsize;
      s_d.req.write = hwrite;
      s_d.wr_pend   = hwrite;
      s_d.rd_pend   = !hwrite;
      s_d.hreadyout = hwrite;
    end

    // Write data phase: the monitor checks each step of the sequence
    if (s_q.wr_pend) begin
      if (is_array) begin
        if (s_q.access_error_flag || s_q.protection_violation_flag) begin
          // Refused until software clears both flags
          s_d.state = s_q.state;
        end else if (!s_q.div_loaded) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_NO_DIV;
        end else if (s_q.emu_s2) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_EMU;
        end else if (s_q.req.size != HSIZE_WORD) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_SIZE;
        end else if (s_q.state == SEQ_DATA) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_NOT_CMD;
        end else if (s_q.state == SEQ_CMD) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_NOT_LNCH;
        end else if (!command_buffer_empty_flag) begin
          acc_set   = 1'b1;
          cause_new = CAUSE_NOT_EMPT;
        end else if (s_q.prot[sector]) begin
          pv_set    = 1'b1;
          cause_new = CAUSE_PROT;
        end else begin
          s_d.arr_data = hwdata;
          s_d.state    = SEQ_DATA;
        end
      end else begin
        unique case (s_q.state)
          SEQ_IDLE: begin
            if (off == OFF_CLKDIV) begin
              s_d.div        = hwdata[DIV_W-1:0];
              s_d.div_loaded = 1'b1;
            end else if (off == OFF_PROT) begin
              s_d.prot = hwdata;
            end else if (off == OFF_USTAT) begin
              acc_clr = hwdata[USTAT_ACCESS_ERROR_FLAG_BIT];
              pv_clr  = hwdata[USTAT_PROTECTION_VIOLATION_FLAG_BIT];
            end else if (off == OFF_CMD) begin
              // A command with no longword before it is an illegal step
              acc_set   = 1'b1;
              cause_new = s_q.queued ? CAUSE_SECOND : CAUSE_NO_DATA;
            end
          end
          SEQ_DATA: begin
            if (off == OFF_CMD) begin
              if (hwdata[7:0] != CMD_PROGRAM && hwdata[7:0] != CMD_PAGE_ERASE &&
                  hwdata[7:0] != CMD_MASS_ERASE && hwdata[7:0] != CMD_VERIFY) begin
                acc_set   = 1'b1;
                cause_new = CAUSE_BAD_CMD;
              end else if (hwdata[7:0] == CMD_MASS_ERASE && (|s_q.prot)) begin
                pv_set    = 1'b1;
                cause_new = CAUSE_MASS;
              end else begin
                s_d.cmd   = hwdata[7:0];
                s_d.state = SEQ_CMD;
              end
            end else if (off == OFF_USTAT && !hwdata[USTAT_COMMAND_BUFFER_EMPTY_FLAG_BIT]) begin
              acc_set   = 1'b1;
              cause_new = CAUSE_CB_ABORT;
            end else begin
              acc_set   = 1'b1;
              cause_new = CAUSE_NOT_CMD;
            end
          end
          SEQ_CMD: begin
            if (off == OFF_USTAT && hwdata[USTAT_COMMAND_BUFFER_EMPTY_FLAG_BIT]) begin
              // Launch: the command waits here if the previous one still runs
              s_d.queued = 1'b1;
              s_d.state  = SEQ_IDLE;
            end else if (off == OFF_USTAT) begin
              acc_set   = 1'b1;
              cause_new = CAUSE_CB_ABORT;
            end else if (off == OFF_CMD) begin
              acc_set   = 1'b1;
              cause_new = CAUSE_SECOND;
            end else begin
              acc_set   = 1'b1;
              cause_new = CAUSE_NOT_LNCH;
            end
          end
          default: begin
            s_d.state = SEQ_IDLE;
          end
        endcase
      end
    end

    // Any refused step drops the open sequence at once
    if (acc_set || pv_set) begin
      s_d.state = SEQ_IDLE;
    end

    // Hand a launched command to the timer once it is free
    if (s_q.queued && !tmr_busy && !stop_rise) begin
      tmr_start  = 1'b1;
      s_d.queued = 1'b0;
    end

    // Stop entry: software should never do this mid-command, cells are left undefined
    if (stop_rise) begin
      if (tmr_busy || s_q.queued) begin
        tmr_abort  = 1'b1;
        s_d.queued = 1'b0;
        acc_set    = 1'b1;
        cause_new  = CAUSE_STOP;
      end
      s_d.state = SEQ_IDLE;
    end

    // Hardware set wins over a software clear in the same cycle
    s_d.access_error_flag = (s_q.access_error_flag && !acc_clr) || acc_set;
    s_d.protection_violation_flag  = (s_q.protection_violation_flag && !pv_clr) || pv_set;
    if (acc_set || pv_set) begin
      s_d.cause = cause_new;
    end
    s_d.hv_on = tmr_busy && !tmr_abort && !tmr_done;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.hresp     <= HRESP_OKAY;
      s_q.state     <= SEQ_IDLE;
      s_q.prot      <= PROT_RESET;
      s_q.cmd       <= CMD_RESET;
      s_q.cause     <= CAUSE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata          = s_q.hrdata;
  assign hreadyout       = s_q.hreadyout;
  assign hresp           = s_q.hresp;
  assign high_voltage_on = s_q.hv_on;

endmodule

/* File: dv/fcsm_master.sv */
// Bus master partner that issues single transfers of a given size to the monitor
`timescale 1ns/1ps
module fcsm_master
  import fcsm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end

  // A slave that never answers ends the run as a failure
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (k >= 64) begin
      fcsm_top_bench.n_fail++;
      fcsm_top_bench.print_verdict();
    end
  endtask

  // Released address and data lines show the inverse so stale values never look valid
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= s;
    wait_rdy();
    hsel <= 1'b0;
    haddr <= ~a;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* File: dv/fcsm_chk.sv */
// Port-level checker of the flash command sequence monitor
`timescale 1ns/1ps
module fcsm_chk
  import fcsm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic [1:0]  hresp,
  input wire logic        stop_mode_req,
  input wire logic        emulation_mode,
  input wire logic        high_voltage_on
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && htrans[1] && hready;

  resp_okay_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read timing wrong");
  stall_cause_a: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("stall without read");
  rd_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  busy_read_a: assert property (
    take && !hwrite && haddr[ARRAY_SEL_BIT] && high_voltage_on ##1 high_voltage_on
    |=> hrdata == ARRAY_INVALID_WORD) else $error("busy read not invalid");
  stop_off_a: assert property ($rose(stop_mode_req) |-> ##[1:6] !high_voltage_on)
    else $error("voltage stays on in stop");
  exit_quiet_a: assert property (
    stop_mode_req [*6] ##1 !stop_mode_req |-> !high_voltage_on [*6])
    else $error("pending command ran after stop");

  busy_rd_c: cover property (take && !hwrite && haddr[ARRAY_SEL_BIT] && high_voltage_on);
  stop_c: cover property ($rose(stop_mode_req) && high_voltage_on);
  done_c: cover property ($fell(high_voltage_on) && !stop_mode_req);
endmodule

bind fcsm_top fcsm_chk fcsm_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .stop_mode_req,
  .emulation_mode, .high_voltage_on);

/* File: dv/fcsm_top_bench.sv */
// Self-checking bench of the flash command sequence monitor
`timescale 1ns/1ps
module fcsm_top_bench
  import fcsm_pkg::*;
;
  logic        hclk, hresetn, stop_mode_req, emulation_mode;
  logic        hsel, hwrite, hreadyout, high_voltage_on;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  int          n_fail, checks;
  localparam logic [31:0] ARR  = 32'h0008_0000;
  localparam logic [31:0] R_DV = {24'h0, OFF_CLKDIV};
  localparam logic [31:0] R_PR = {24'h0, OFF_PROT};
  localparam logic [31:0] R_US = {24'h0, OFF_USTAT};
  localparam logic [31:0] R_CM = {24'h0, OFF_CMD};
  localparam logic [31:0] R_ST = {24'h0, OFF_STAT};
  localparam logic [31:0] R_CA = {24'h0, OFF_CAUSE};
  localparam logic [31:0] ACC  = 32'h1 << USTAT_ACCESS_ERROR_FLAG_BIT;
  localparam logic [31:0] PV   = 32'h1 << USTAT_PROTECTION_VIOLATION_FLAG_BIT;

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  fcsm_top fcsm_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stop_mode_req, .emulation_mode,
    .high_voltage_on);
  fcsm_master fcsm_master_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    fcsm_master_i.xfer(a, 1'b1, HSIZE_WORD, d, r);
  endtask

  task automatic rc(input string nm, input logic [31:0] a, m, e);
    logic [31:0] r;
    fcsm_master_i.xfer(a, 1'b0, HSIZE_WORD, 32'h0, r);
    chk(nm, e, r & m);
  endtask

  // Refused step: flag, cause and idle state, then clearing re-arms the monitor
  task automatic flagged(input fcsm_cause_e c, input logic [31:0] f);
    rc("flags", R_US, 32'h30, f);
    rc("cause", R_CA, 32'hF, {28'h0, c});
    rc("state", R_ST, 32'h3, 32'h0);
    wr(R_US, 32'h30);
    rc("cleared", R_US, 32'h30, 32'h0);
  endtask

  task automatic wait_hv(input logic v);
    int k;
    k = 0;
    while (high_voltage_on !== v && k < 1500) begin
      @(posedge hclk);
      k++;
    end
    chk("hv", {31'h0, v}, {31'h0, high_voltage_on});
    // A command that never starts or never ends closes the run as a failure
    if (k >= 1500) begin
      print_verdict();
    end
  endtask

  task automatic t_init();
    rc("div reset", R_DV, 32'hFF, 32'h0);
    wr(ARR, 32'h1);
    flagged(CAUSE_NO_DIV, ACC);
    wr(R_DV, 32'h0);
    rc("div loaded", R_DV, 32'hFF, 32'h80);
    wr(32'h20, 32'h5);
    rc("unmapped", 32'h20, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic t_emu();
    emulation_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    wr(ARR, 32'h1);
    flagged(CAUSE_EMU, ACC);
    emulation_mode <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic t_size();
    logic [31:0] r;
    for (int s = 0; s < 2; s++) begin
      fcsm_master_i.xfer(ARR, 1'b1, 3'(s), 32'h1, r);
      flagged(CAUSE_SIZE, ACC);
    end
  endtask

  task automatic t_order();
    wr(ARR, 32'h1);
    wr(R_CM, 32'h7F);
    flagged(CAUSE_BAD_CMD, ACC);
    wr(ARR, 32'h1);
    wr(R_PR, 32'h0);
    flagged(CAUSE_NOT_CMD, ACC);
    wr(ARR, 32'h1);
    wr(R_CM, {24'h0, CMD_PROGRAM});
    wr(R_CM, {24'h0, CMD_PROGRAM});
    flagged(CAUSE_SECOND, ACC);
    wr(ARR, 32'h1);
    wr(R_CM, {24'h0, CMD_PROGRAM});
    wr(R_DV, 32'h0);
    flagged(CAUSE_NOT_LNCH, ACC);
    wr(ARR, 32'h1);
    wr(R_US, 32'h0);
    flagged(CAUSE_CB_ABORT, ACC);
    wr(ARR, 32'h1);
    wr(R_CM, {24'h0, CMD_PROGRAM});
    wr(R_US, 32'h0);
    flagged(CAUSE_CB_ABORT, ACC);
    chk("no run", 32'h0, {31'h0, high_voltage_on});
  endtask

  task automatic t_prot();
    wr(R_PR, 32'h1);
    wr(ARR, 32'h1);
    flagged(CAUSE_PROT, PV);
    wr(ARR | 32'h4000, 32'h1);
    wr(R_CM, {24'h0, CMD_MASS_ERASE});
    flagged(CAUSE_MASS, PV);
    wr(R_PR, 32'h0);
  endtask

  // Two erases, one queued; the chip is stopped mid-erase on purpose
  task automatic t_busy();
    for (int i = 0; i < 2; i++) begin
      wr(ARR, 32'h1);
      wr(R_CM, {24'h0, CMD_PAGE_ERASE});
      wr(R_US, 32'h80);
    end
    rc("busy read", ARR, 32'hFFFF_FFFF, ARRAY_INVALID_WORD);
    rc("busy flags", R_US, 32'hF0, 32'h0);
    wr(ARR, 32'h1);
    flagged(CAUSE_NOT_EMPT, ACC);
    stop_mode_req <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("hv stop", 32'h0, {31'h0, high_voltage_on});
    rc("stop flags", R_US, 32'h50, 32'h50);
    flagged(CAUSE_STOP, ACC);
    stop_mode_req <= 1'b0;
    repeat (20) @(posedge hclk);
    rc("dropped", R_ST, 32'hC, 32'h0);
  endtask

  task automatic t_good();
    logic [7:0] c[4];
    c = '{CMD_PROGRAM, CMD_PAGE_ERASE, CMD_MASS_ERASE, CMD_VERIFY};
    for (int i = 0; i < 4; i++) begin
      wr(ARR + 32'h8, 32'hA5 + i);
      wr(R_CM, {24'h0, c[i]});
      wr(R_US, 32'h80);
      wait_hv(1'b1);
      wait_hv(1'b0);
      rc("cmd", R_CM, 32'hFF, {24'h0, c[i]});
      rc("done", R_US, 32'hF0, 32'hC0);
      rc("word", ARR + 32'h8, 32'hFFFF_FFFF, 32'hA5 + i);
    end
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    hresetn = 1'b0;
    stop_mode_req = 1'b0;
    emulation_mode = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_init();
    t_emu();
    t_size();
    t_order();
    t_prot();
    t_busy();
    t_good();
    print_verdict();
  end
endmodule
